// ---- logic/sel_flag_pkg.sv ----
// Constants and types shared by the serial-port flag, interrupt and DMA logic
`default_nettype none
package sel_flag_pkg;

	// Flag positions in flag_status_reg, irq_enable_reg and flag_clear_reg
	localparam int unsigned FLAG_W        = 8;
	localparam int unsigned BIT_TX_VACANT = 0;
	localparam int unsigned BIT_RX_FULL   = 1;
	localparam int unsigned BIT_SEL_FALL  = 2;
	localparam int unsigned BIT_SEL_RISE  = 3;
	localparam int unsigned BIT_TX_STARVE = 4;
	localparam int unsigned BIT_RX_LOST   = 5;
	localparam int unsigned BIT_SEL_ABORT = 6;
	localparam int unsigned BIT_MM_FAULT  = 7;

	// Reset values
	localparam logic [7:0] FLAG_RST       = 8'h01;
	localparam logic       SEL_LEVEL_RST  = 1'h1;
	localparam logic       ENABLE_RST     = 1'h0;

	// Synchroniser depth for signals from another clock or a pin
	localparam int unsigned SYNC_DEPTH    = 3;

	// Number of link events carried across to the peripheral clock
	localparam int unsigned LINK_EVT_W    = 2;
	localparam int unsigned EVT_START     = 0;
	localparam int unsigned EVT_DONE      = 1;

	typedef logic [FLAG_W-1:0] flag_vec_t;

	// Frame tracking: deselected -> in frame (Gray along the path)
	typedef enum logic [0:0] {
		FRAME_IDLE   = 1'b0,
		FRAME_ACTIVE = 1'b1
	} frame_state_e;

endpackage : sel_flag_pkg
`default_nettype wire

// ---- logic/stable_sync.sv ----
// Three-stage synchroniser that reports a level once stages two and three agree
`timescale 1ns/1ns
`default_nettype none
module stable_sync #(
	parameter int unsigned         W       = 1,
	parameter logic        [W-1:0] RST_VAL = '0
) (
	input  wire logic         clk,
	input  wire logic         rst_b,
	input  wire logic [W-1:0] async_in,
	output logic      [W-1:0] level
);
	import sel_flag_pkg::*;

	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
		logic [W-1:0] s3;
		logic [W-1:0] lvl;
	} sync_s;

	sync_s st_r;
	sync_s st_nxt;

	always_comb begin
		st_nxt    = st_r;
		st_nxt.s1 = async_in;
		st_nxt.s2 = st_r.s1;
		st_nxt.s3 = st_r.s2;
		// A bit moves only when the last two stages agree, filtering one-stage glitches
		for (int i = 0; i < int'(W); i++) begin
			if (st_r.s2[i] == st_r.s3[i]) begin
				st_nxt.lvl[i] = st_r.s3[i];
			end
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			st_r <= '{s1: RST_VAL, s2: RST_VAL, s3: RST_VAL, lvl: RST_VAL};
		end else begin
			st_r <= st_nxt;
		end
	end

	assign level = st_r.lvl;

endmodule : stable_sync
`default_nettype wire

// ---- logic/link_event_xfer.sv ----
// Carries frame-start and frame-done pulses from the link clock to the peripheral clock
`timescale 1ns/1ns
`default_nettype none
module link_event_xfer (
	input  wire logic                                link_clk,
	input  wire logic                                ref_clk,
	input  wire logic                                rst_b,
	input  wire logic [sel_flag_pkg::LINK_EVT_W-1:0] evt_link,
	output logic      [sel_flag_pkg::LINK_EVT_W-1:0] evt_pulse
);
	import sel_flag_pkg::*;

	typedef struct packed {
		logic [LINK_EVT_W-1:0] tgl;
	} lk_s;

	typedef struct packed {
		logic [LINK_EVT_W-1:0] seen;
		logic [LINK_EVT_W-1:0] pulse;
	} rf_s;

	lk_s                   lk_r;
	lk_s                   lk_nxt;
	rf_s                   rf_r;
	rf_s                   rf_nxt;
	logic [LINK_EVT_W-1:0] tgl_ref;

	// Toggle per event: the link clock may stop right after a frame, so no pulse is held there
	always_comb begin
		lk_nxt     = lk_r;
		lk_nxt.tgl = lk_r.tgl ^ evt_link;
	end

	always_ff @(posedge link_clk or negedge rst_b) begin
		if (!rst_b) begin
			lk_r <= '0;
		end else begin
			lk_r <= lk_nxt;
		end
	end

	stable_sync #(
		.W       (LINK_EVT_W),
		.RST_VAL ('0)
	) u_tgl_sync (
		.clk      (ref_clk),
		.rst_b    (rst_b),
		.async_in (lk_r.tgl),
		.level    (tgl_ref)
	);

	always_comb begin
		rf_nxt       = rf_r;
		rf_nxt.seen  = tgl_ref;
		rf_nxt.pulse = tgl_ref ^ rf_r.seen;
	end

	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			rf_r <= '0;
		end else begin
			rf_r <= rf_nxt;
		end
	end

	assign evt_pulse = rf_r.pulse;

endmodule : link_event_xfer
`default_nettype wire

// ---- logic/spi_flag_irq_dma_logic.sv ----
// Status, error, interrupt and DMA-request logic of the synchronous serial port
`timescale 1ns/1ns
`default_nettype none
module spi_flag_irq_dma_logic (
	input  wire logic                     ref_clk,
	input  wire logic                     rst_b,
	input  wire logic                     link_clk,
	input  wire logic                     sel_in_b,
	input  wire logic                     master_mode,
	input  wire logic                     sel_pin_is_input,
	input  wire logic                     enable_set,
	input  wire logic                     enable_clear,
	input  wire logic                     send_dma_request_enable,
	input  wire logic                     recv_dma_request_enable,
	input  wire sel_flag_pkg::flag_vec_t  irq_enable_reg,
	input  wire logic                     flag_clear_wr,
	input  wire sel_flag_pkg::flag_vec_t  flag_clear_reg,
	input  wire logic                     data_window_rd,
	input  wire logic                     data_window_wr,
	input  wire logic                     tx_shift_load,
	input  wire logic                     frame_start_link,
	input  wire logic                     frame_done_link,
	output sel_flag_pkg::flag_vec_t       flag_status_reg,
	output logic                          sel_level,
	output logic                          ctrl_enable,
	output logic                          frame_abort,
	output logic                          rx_buffer_load,
	output logic                          irq,
	output logic                          tx_dma_req,
	output logic                          rx_dma_req
);
	import sel_flag_pkg::*;

	typedef struct packed {
		flag_vec_t    flags;
		logic         sel_lvl;
		logic         enable;
		frame_state_e frame;
		logic         abort;
		logic         rx_load;
		logic         irq;
	} core_s;

	core_s                 st_r;
	core_s                 st_nxt;
	logic                  sel_sync;
	logic [LINK_EVT_W-1:0] link_evt;
	logic                  frame_start;
	logic                  frame_done;
	logic                  sel_fell;
	logic                  sel_rose;
	logic                  slave_mode;
	flag_vec_t             set_vec;
	flag_vec_t             clr_vec;

	// Clear mask from the clear strobe: a zero bit clears, a one bit leaves the flag
	function automatic flag_vec_t zero_clears(input logic wr, input flag_vec_t data);
		zero_clears = wr ? ~data : '0;
	endfunction : zero_clears

	// The pin is asynchronous; every edge is counted once on the stable level
	stable_sync #(
		.W       (1),
		.RST_VAL (SEL_LEVEL_RST)
	) u_sel_sync (
		.clk      (ref_clk),
		.rst_b    (rst_b),
		.async_in (sel_in_b),
		.level    (sel_sync)
	);

	link_event_xfer u_link_xfer (
		.link_clk  (link_clk),
		.ref_clk   (ref_clk),
		.rst_b     (rst_b),
		.evt_link  ({frame_done_link, frame_start_link}),
		.evt_pulse (link_evt)
	);

	assign frame_start = link_evt[EVT_START];
	assign frame_done  = link_evt[EVT_DONE];
	assign slave_mode  = !master_mode;
	assign sel_fell    = st_r.sel_lvl && !sel_sync;
	assign sel_rose    = !st_r.sel_lvl && sel_sync;

	always_comb begin
		set_vec = '0;
		clr_vec = zero_clears(flag_clear_wr, flag_clear_reg);

		set_vec[BIT_SEL_FALL] = sel_fell;
		set_vec[BIT_SEL_RISE] = sel_rose;

		// Fault only checked while enabled, else a held-low select would refill the flag
		set_vec[BIT_MM_FAULT] = st_r.enable && master_mode && sel_pin_is_input && !sel_sync;

		set_vec[BIT_SEL_ABORT] = slave_mode && sel_rose && (st_r.frame == FRAME_ACTIVE);

		// A read in the same cycle empties the buffer first, so no frame is lost
		set_vec[BIT_RX_LOST] = frame_done && st_r.flags[BIT_RX_FULL] && !data_window_rd;
		set_vec[BIT_RX_FULL] = frame_done;

		set_vec[BIT_TX_STARVE] = slave_mode && frame_start && st_r.flags[BIT_TX_VACANT];

		set_vec[BIT_TX_VACANT] = tx_shift_load;
		clr_vec[BIT_TX_VACANT] = data_window_wr;
		clr_vec[BIT_RX_FULL]   = clr_vec[BIT_RX_FULL] || data_window_rd;
	end

	always_comb begin
		st_nxt = st_r;
		st_nxt.sel_lvl = sel_sync;
		st_nxt.abort   = 1'b0;
		st_nxt.rx_load = 1'b0;

		// Set wins over clear; sticky error flags stay until cleared by software
		st_nxt.flags = (st_r.flags & ~clr_vec) | set_vec;

		// Software enable; a fault in the same cycle as a set still forces it off
		if (enable_set) begin
			st_nxt.enable = 1'b1;
		end
		if (enable_clear) begin
			st_nxt.enable = 1'b0;
		end
		if (set_vec[BIT_MM_FAULT]) begin
			st_nxt.enable = 1'b0;
		end

		case (st_r.frame)
			FRAME_IDLE: begin
				// In slave mode a new frame only begins while selected, which resumes after an abort; master mode needs no select
				if (frame_start && !frame_done && (master_mode || !sel_sync)) begin
					st_nxt.frame = FRAME_ACTIVE;
				end
			end
			FRAME_ACTIVE: begin
				if (set_vec[BIT_SEL_ABORT]) begin
					st_nxt.frame = FRAME_IDLE;
					st_nxt.abort = 1'b1;
				end else if (frame_done) begin
					st_nxt.frame = FRAME_IDLE;
				end
			end
			default: begin
				st_nxt.frame = FRAME_IDLE;
			end
		endcase

		// Every finished frame loads the buffer, overwriting unread data on overrun
		if (frame_done) begin
			st_nxt.rx_load = 1'b1;
		end

		// One line for all eight sources, registered so it starts with the flag
		st_nxt.irq = |(st_nxt.flags & irq_enable_reg);
	end

	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			st_r <= '{
				flags:   FLAG_RST,
				sel_lvl: SEL_LEVEL_RST,
				enable:  ENABLE_RST,
				frame:   FRAME_IDLE,
				abort:   1'b0,
				rx_load: 1'b0,
				irq:     1'b0
			};
		end else begin
			st_r <= st_nxt;
		end
	end

	assign flag_status_reg = st_r.flags;
	assign sel_level       = st_r.sel_lvl;
	assign ctrl_enable     = st_r.enable;
	assign frame_abort     = st_r.abort;
	assign rx_buffer_load  = st_r.rx_load;
	assign irq             = st_r.irq;

	// Requests are levels; the DMA write or read itself clears the flag and drops them
	assign tx_dma_req = send_dma_request_enable && st_r.flags[BIT_TX_VACANT];
	assign rx_dma_req = recv_dma_request_enable && st_r.flags[BIT_RX_FULL];

endmodule : spi_flag_irq_dma_logic
`default_nettype wire

// ---- dv/spi_flag_irq_dma_logic_assertions.sv ----
// Concurrent checks on the serial flag, interrupt and DMA block
`timescale 1ns/1ns
`default_nettype none
module spi_flag_chk (
	input wire logic                    ref_clk,
	input wire logic                    rst_b,
	input wire logic                    sel_level,
	input wire logic                    master_mode,
	input wire logic                    sel_pin_is_input,
	input wire logic                    ctrl_enable,
	input wire sel_flag_pkg::flag_vec_t flag_status_reg,
	input wire sel_flag_pkg::flag_vec_t irq_enable_reg,
	input wire logic                    irq,
	input wire logic                    flag_clear_wr,
	input wire sel_flag_pkg::flag_vec_t flag_clear_reg,
	input wire logic                    data_window_rd,
	input wire logic                    data_window_wr,
	input wire logic                    tx_shift_load,
	input wire logic                    rx_buffer_load,
	input wire logic                    frame_abort,
	input wire logic                    send_dma_request_enable,
	input wire logic                    tx_dma_req
);
	import sel_flag_pkg::*;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rst_b);
	sequence mm_hit;
		ctrl_enable && master_mode && sel_pin_is_input && !sel_level;
	endsequence
	AST_FALL: assert property ($fell(sel_level) |-> flag_status_reg[BIT_SEL_FALL])
		else $error("fall flag missing");
	AST_RISE: assert property ($rose(sel_level) |-> flag_status_reg[BIT_SEL_RISE])
		else $error("rise flag missing");
	AST_MMF: assert property (mm_hit |=> flag_status_reg[BIT_MM_FAULT] && !ctrl_enable)
		else $error("mode fault not taken");
	AST_MMCLR: assert property (flag_clear_wr && !flag_clear_reg[BIT_MM_FAULT] && !ctrl_enable
		|=> !flag_status_reg[BIT_MM_FAULT]) else $error("fault flag not cleared");
	AST_ABORT: assert property (frame_abort |-> flag_status_reg[BIT_SEL_ABORT] ##1 !frame_abort)
		else $error("abort pulse wrong");
	AST_LOAD: assert property (rx_buffer_load |-> flag_status_reg[BIT_RX_FULL])
		else $error("receive full missing");
	AST_RDCLR: assert property (data_window_rd |=> !flag_status_reg[BIT_RX_FULL] || rx_buffer_load)
		else $error("read did not clear");
	AST_WRCLR: assert property (data_window_wr && !tx_shift_load |=> !flag_status_reg[BIT_TX_VACANT])
		else $error("write did not clear");
	AST_IRQ: assert property ($stable(irq_enable_reg) |-> irq == |(flag_status_reg & irq_enable_reg))
		else $error("irq mismatch");
	AST_TXDMA: assert property (tx_dma_req == (send_dma_request_enable && flag_status_reg[BIT_TX_VACANT]))
		else $error("tx dma mismatch");
endmodule : spi_flag_chk
`default_nettype wire

// ---- dv/link_peer.sv ----
// Far-side serial master: select pin and link-clocked frame events
`timescale 1ns/1ns
`default_nettype none
module link_peer (
	output var logic link_clk,
	output var logic sel_in_b,
	output var logic frame_start_link,
	output var logic frame_done_link
);
	initial begin
		{link_clk, frame_start_link, frame_done_link} = '0;
		sel_in_b = 1'b1;
	end
	// Clock stands still between frames
	task automatic tick;
		#62 link_clk = 1'b1;
		#63 link_clk = 1'b0;
	endtask : tick
	task automatic set_sel(input logic v);
		sel_in_b = v;
	endtask : set_sel
	task automatic xfer(input bit abort);
		frame_start_link = 1'b1;
		tick();
		frame_start_link = 1'b0;
		repeat (4) tick();
		if (abort) begin
			sel_in_b = 1'b1;
		end else begin
			frame_done_link = 1'b1;
			tick();
			frame_done_link = 1'b0;
		end
		tick();
	endtask : xfer
endmodule : link_peer
`default_nettype wire

// ---- dv/tb_spi_flag_irq_dma_logic.sv ----
// Directed bench for the serial flag, interrupt and DMA block
`timescale 1ns/1ns
`default_nettype none
module tb_spi_flag_irq_dma_logic;
	import sel_flag_pkg::*;
	logic ref_clk, rst_b, link_clk, sel_in_b, frame_start_link, frame_done_link;
	logic master_mode, sel_pin_is_input, enable_set, enable_clear;
	logic send_dma_request_enable, recv_dma_request_enable;
	logic flag_clear_wr, data_window_rd, data_window_wr, tx_shift_load;
	logic sel_level, ctrl_enable, frame_abort, rx_buffer_load, irq, tx_dma_req, rx_dma_req;
	flag_vec_t irq_enable_reg, flag_clear_reg, flag_status_reg;
	int n_errors, samples_checked;
	// Strobe codes in the order {enable_set, enable_clear, flag_clear_wr, data_window_rd, data_window_wr, tx_shift_load}
	localparam logic [5:0] S_SET  = 6'h20;
	localparam logic [5:0] S_CLR  = 6'h10;
	localparam logic [5:0] S_FCLR = 6'h08;
	localparam logic [5:0] S_RD   = 6'h04;
	localparam logic [5:0] S_WR   = 6'h02;
	localparam logic [5:0] S_LOAD = 6'h01;

	spi_flag_irq_dma_logic dut_u (.ref_clk, .rst_b, .link_clk, .sel_in_b, .master_mode,
		.sel_pin_is_input, .enable_set, .enable_clear, .send_dma_request_enable,
		.recv_dma_request_enable, .irq_enable_reg, .flag_clear_wr, .flag_clear_reg,
		.data_window_rd, .data_window_wr, .tx_shift_load, .frame_start_link,
		.frame_done_link, .flag_status_reg, .sel_level, .ctrl_enable, .frame_abort,
		.rx_buffer_load, .irq, .tx_dma_req, .rx_dma_req);
	link_peer peer_u (.link_clk, .sel_in_b, .frame_start_link, .frame_done_link);

	initial begin
		ref_clk = 1'b0;
		forever #25 ref_clk = ~ref_clk;
	end

	task automatic cyc(input int n);
		repeat (n) @(negedge ref_clk);
	endtask : cyc
	// One strobe per call, then a quiet cycle so back-to-back calls never rewrite a strobe in one step
	task automatic pulse(input logic [5:0] which);
		{enable_set, enable_clear, flag_clear_wr, data_window_rd, data_window_wr, tx_shift_load} = which;
		cyc(1);
		{enable_set, enable_clear, flag_clear_wr, data_window_rd, data_window_wr, tx_shift_load} = 6'h00;
		cyc(1);
	endtask : pulse
	task automatic clr(input flag_vec_t v);
		flag_clear_reg = v;
		pulse(S_FCLR);
	endtask : clr
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		samples_checked++;
		if (got !== exp) begin
			n_errors++;
			$display("MISMATCH t=%0t got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic wrap_up;
		$display("checks %0d, mismatches %0d", samples_checked, n_errors);
		if (n_errors == 0 && samples_checked > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : wrap_up

	initial begin
		#100000;
		n_errors++;
		$display("MISMATCH t=%0t watchdog expired", $time);
		wrap_up();
	end

	initial begin
		{master_mode, sel_pin_is_input, enable_set, enable_clear, flag_clear_wr} = '0;
		{data_window_rd, data_window_wr, tx_shift_load} = '0;
		{send_dma_request_enable, recv_dma_request_enable} = 2'h3;
		irq_enable_reg = 8'h00;
		flag_clear_reg = 8'hFF;
		rst_b = 1'b0;
		cyc(3);
		rst_b = 1'b1;
		cyc(1);
		chk(flag_status_reg, 8'h01);
		chk({4'h0, tx_dma_req, rx_dma_req, ctrl_enable, irq}, 8'h08);
		$display("test reset done");
		peer_u.set_sel(1'b0);
		cyc(8);
		chk({flag_status_reg[7:1], sel_level}, 8'h04);
		clr(8'hFB);
		chk(flag_status_reg, 8'h01);
		$display("test select edge done");
		peer_u.xfer(1'b0);
		cyc(10);
		chk(flag_status_reg, 8'h13);
		chk({6'h0, tx_dma_req, rx_dma_req}, 8'h03);
		peer_u.xfer(1'b0);
		cyc(10);
		chk(flag_status_reg, 8'h33);
		recv_dma_request_enable = 1'b0;
		cyc(1);
		chk({6'h0, tx_dma_req, rx_dma_req}, 8'h02);
		pulse(S_RD);
		chk(flag_status_reg, 8'h31);
		clr(8'h01);
		pulse(S_WR);
		chk({flag_status_reg[7:1], tx_dma_req}, 8'h00);
		pulse(S_LOAD);
		chk(flag_status_reg, 8'h01);
		send_dma_request_enable = 1'b0;
		cyc(1);
		chk({7'h0, tx_dma_req}, 8'h00);
		send_dma_request_enable = 1'b1;
		$display("test frames done");
		peer_u.xfer(1'b1);
		cyc(10);
		chk({flag_status_reg[7:1], sel_level}, 8'h59);
		peer_u.set_sel(1'b0);
		cyc(8);
		peer_u.xfer(1'b0);
		cyc(10);
		chk(flag_status_reg, 8'h5F);
		$display("test abort done");
		irq_enable_reg = 8'h40;
		cyc(2);
		chk({7'h0, irq}, 8'h01);
		clr(8'hBF);
		chk({flag_status_reg[7:1], irq}, 8'h1E);
		clr(8'h00);
		irq_enable_reg = 8'hFF;
		cyc(2);
		chk({flag_status_reg[7:1], irq}, 8'h01);
		irq_enable_reg = 8'h00;
		$display("test interrupt done");
		{master_mode, sel_pin_is_input} = 2'h3;
		pulse(S_SET);
		cyc(2);
		chk({flag_status_reg[7:1], ctrl_enable}, 8'h80);
		peer_u.set_sel(1'b1);
		cyc(8);
		pulse(S_SET);
		cyc(1);
		chk({flag_status_reg[7:1], ctrl_enable}, 8'h89);
		pulse(S_CLR);
		chk({flag_status_reg[7:1], ctrl_enable}, 8'h88);
		clr(8'h7F);
		chk({flag_status_reg[7:1], ctrl_enable}, 8'h08);
		$display("test mode fault done");
		wrap_up();
	end
endmodule : tb_spi_flag_irq_dma_logic

bind spi_flag_irq_dma_logic spi_flag_chk chk_u (.ref_clk, .rst_b, .sel_level, .master_mode,
	.sel_pin_is_input, .ctrl_enable, .flag_status_reg, .irq_enable_reg, .irq, .flag_clear_wr,
	.flag_clear_reg, .data_window_rd, .data_window_wr, .tx_shift_load, .rx_buffer_load,
	.frame_abort, .send_dma_request_enable, .tx_dma_req);
`default_nettype wire
